// ### src/sdd_ctrl.v
// Supply drop detector mode and supply warning control block
//
// Overview of operation
// RULE1: awake mode loaded from fuse at reset
// RULE2: deep-sleep mode loaded from fuse at reset
// RULE3: awake mode field ignores software writes
// RULE4: sleep entry switches detector to sleep mode
// RULE5: wake-up returns detector to awake mode
// RULE6: software writes key, then field within four
// RULE7: protected writes accepted, ignored without unlock
// RULE8: rate bit selects 1 kHz or 125 Hz
// RULE9: awake mode codes off, on, sampled, hold
// RULE10: sleep mode codes off, on, sampled, reserved
// RULE11: three-bit threshold read-only from fuse
// RULE12: margin codes 5, 15, 25 percent
// RULE13: direction falling, rising or either crossing
// RULE14: enable bit gates warning interrupt
// RULE15: flag set on selected crossing
// RULE16: flag updates only while detector enabled
// RULE17: status reads one when supply below warning
// RULE18: warning monitor follows detector mode; the code also needs warning_irq_enable set
// RULE19: request while enable and flag both set
// RULE20: writing one clears flag, zero keeps
// RULE21: sampled mode compares in brief periodic windows
`timescale 1ns/10ps
`default_nettype none
`include "sdd_defs.vh"
module sdd_ctrl #(
  parameter FAST_CYCLES = `SDD_FAST_CYCLES,
  parameter SLOW_CYCLES = `SDD_SLOW_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  // Avalon-MM slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  // Fuse byte and key write from the CPU protection register
  input  wire [7:0]  detector_fuse_byte,
  input  wire        change_protection_write,
  input  wire [7:0]  change_protection_data,
  // Sleep state and warning comparator
  input  wire        deep_sleep,
  input  wire        below_warning_raw,
  // Detector controls
  output reg  [1:0]  detector_mode,
  output reg         detector_enable,
  output reg  [2:0]  threshold_level,
  output reg  [1:0]  warning_margin,
  output reg         monitor_enable,
  output reg         warning_irq
);
  // Register state
  reg       sample_rate_select;
  reg [1:0] awake_mode;
  reg [1:0] sleep_mode;
  reg [1:0] warning_direction;
  reg       warning_irq_enable;
  reg       warning_irq_flag;
  reg       below_warning_status;
  reg       fuse_loaded;
  reg [2:0] unlock_left;
  // Synchronisers
  reg       sleep_s1;
  reg       sleep_s2;
  reg       below_s1;
  reg       below_s2;
  reg       below_prev;
  reg       prev_valid;
  // Bus handshake
  reg       bus_busy;
  wire      sample_window;

  wire [3:0] reg_idx  = avs_address[5:2];
  wire       access   = (avs_read | avs_write) & avs_waitrequest & ~bus_busy;
  // Write lands at the edge where the master sees waitrequest low
  wire       wr_take  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire       unlocked = (unlock_left != 3'h0);

  // Two-stage synchronisers for outside levels
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      below_s1 <= 1'b0;
      below_s2 <= 1'b0;
    end else begin
      sleep_s1 <= deep_sleep;
      sleep_s2 <= sleep_s1;
      below_s1 <= below_warning_raw;
      below_s2 <= below_s1;
    end
  end

  // Effective mode selection
  reg [1:0] next_mode;
  always @* begin
    // RULE4 sleep uses sleep mode
    // RULE5 awake uses awake mode
    if (sleep_s2)
      next_mode = sleep_mode;
    else
      next_mode = awake_mode;
  end

  // Detector is on for every mode but off
  wire mode_on      = (next_mode != `SDD_MODE_OFF);
  wire mode_sampled = (next_mode == `SDD_MODE_SAMPLED);

  // RULE21 sampled mode window timer
  // RULE8 rate bit picks the longer period
  sdd_sampler #(
    .FAST_CYCLES (FAST_CYCLES),
    .SLOW_CYCLES (SLOW_CYCLES)
  ) u_sampler (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (mode_sampled),
    .slow   (sample_rate_select),
    .window (sample_window)
  );

  // RULE18 monitor follows detector mode while warning_irq_enable is set
  wire eval_now = mode_on & (~mode_sampled | sample_window);

  // Crossing detection against last evaluated level
  wire fell = eval_now & prev_valid & below_s2 & ~below_prev;
  wire rose = eval_now & prev_valid & ~below_s2 & below_prev;
  reg  hit;
  always @* begin
    // RULE13 direction selects crossing kind
    case (warning_direction)
      `SDD_DIR_FALL: hit = fell;
      `SDD_DIR_RISE: hit = rose;
      `SDD_DIR_BOTH: hit = fell | rose;
      default:       hit = 1'b0;
    endcase
  end

  // Fuse load and protected mode fields
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_loaded        <= 1'b0;
      sample_rate_select <= 1'b0;
      awake_mode         <= `SDD_MODE_OFF;
      sleep_mode         <= `SDD_MODE_OFF;
      threshold_level    <= 3'h0;
    end else if (!fuse_loaded) begin
      // RULE1 awake mode from fuse
      // RULE2 sleep mode from fuse
      // RULE11 threshold from fuse
      fuse_loaded        <= 1'b1;
      sample_rate_select <= detector_fuse_byte[`SDD_RATE_BIT];
      awake_mode <= detector_fuse_byte[`SDD_AWAKE_HI:`SDD_AWAKE_LO];
      sleep_mode <= detector_fuse_byte[`SDD_SLEEP_HI:`SDD_SLEEP_LO];
      threshold_level <= detector_fuse_byte[`SDD_THR_HI:`SDD_THR_LO];
    end else if (wr_take && reg_idx == `SDD_IDX_MODE_CTRL && unlocked) begin
      // RULE3 awake field never written
      // RULE7 sleep field only after unlock
      sleep_mode <= avs_writedata[`SDD_SLEEP_HI:`SDD_SLEEP_LO];
    end
  end

  // Unlock window: key opens it, bus writes use it up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_left <= 3'h0;
    end else if (change_protection_write &&
                 change_protection_data == `SDD_KEY_VALUE) begin
      // RULE6 key opens four-write window
      unlock_left <= `SDD_UNLOCK_WINDOW;
    end else if (wr_take && unlocked) begin
      unlock_left <= unlock_left - 3'h1;
    end
  end

  // Plain control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warning_margin     <= `SDD_MARGIN_RST;
      warning_direction  <= 2'h0;
      warning_irq_enable <= 1'b0;
    end else if (wr_take) begin
      // RULE12 margin code stored as written
      if (reg_idx == `SDD_IDX_MARGIN_CTRL)
        warning_margin <= avs_writedata[`SDD_MARGIN_HI:`SDD_MARGIN_LO];
      // RULE14 interrupt enable bit
      if (reg_idx == `SDD_IDX_IRQ_CTRL) begin
        warning_direction  <= avs_writedata[`SDD_DIR_HI:`SDD_DIR_LO];
        warning_irq_enable <= avs_writedata[`SDD_IE_BIT];
      end
    end
  end

  // Flag, status and crossing history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warning_irq_flag     <= 1'b0;
      below_warning_status <= 1'b0;
      below_prev           <= 1'b0;
      prev_valid           <= 1'b0;
    end else begin
      // RULE15 set on selected crossing, set beats clear
      // RULE16 not set while detector off; write-one clear still works
      // RULE20 write one clears
      if (hit)
        warning_irq_flag <= 1'b1;
      else if (wr_take && reg_idx == `SDD_IDX_IRQ_FLAGS &&
               avs_writedata[`SDD_IF_BIT])
        warning_irq_flag <= 1'b0;
      // RULE17 status tracks evaluated level
      if (eval_now) begin
        below_warning_status <= below_s2;
        below_prev           <= below_s2;
        prev_valid           <= 1'b1;
      end else if (!mode_on) begin
        prev_valid <= 1'b0;
      end
    end
  end

  // Outputs to detector and interrupt controller
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detector_mode   <= `SDD_MODE_OFF;
      detector_enable <= 1'b0;
      monitor_enable  <= 1'b0;
      warning_irq     <= 1'b0;
    end else begin
      // RULE9 awake codes pass through
      // RULE10 sleep codes pass through
      detector_mode   <= next_mode;
      detector_enable <= eval_now;
      monitor_enable  <= eval_now & warning_irq_enable;
      // RULE19 request from enable and flag
      warning_irq     <= warning_irq_enable & warning_irq_flag;
    end
  end

  // Read data mux
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (reg_idx)
      // RULE8 rate bit readable
      `SDD_IDX_MODE_CTRL: rd_byte = {3'h0, sample_rate_select,
                                      awake_mode, sleep_mode};
      `SDD_IDX_THRESHOLD: rd_byte = {5'h00, threshold_level};
      `SDD_IDX_MARGIN_CTRL: rd_byte = {6'h00, warning_margin};
      `SDD_IDX_IRQ_CTRL: rd_byte = {5'h00, warning_direction,
                                     warning_irq_enable};
      `SDD_IDX_IRQ_FLAGS: rd_byte = {7'h00, warning_irq_flag};
      `SDD_IDX_STATUS: rd_byte = {7'h00, below_warning_status};
      default: rd_byte = 8'h00;
    endcase
  end

  wire mapped = (reg_idx == `SDD_IDX_MODE_CTRL) ||
                (reg_idx == `SDD_IDX_THRESHOLD) ||
                (reg_idx >= `SDD_IDX_MARGIN_CTRL &&
                 reg_idx <= `SDD_IDX_STATUS);

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'h0;
      bus_busy        <= 1'b0;
    end else if (access) begin
      avs_waitrequest <= 1'b0;
      bus_busy        <= 1'b1;
      avs_readdata    <= avs_read ? {24'h000000, rd_byte} : 32'h00000000;
      avs_response    <= mapped ? 2'h0 : 2'h2;
    end else begin
      avs_waitrequest <= 1'b1;
      bus_busy        <= 1'b0;
      avs_response    <= 2'h0;
    end
  end
endmodule
`default_nettype wire

// ### src/sdd_defs.vh
// Constants of the supply drop detector control block
`ifndef SDD_DEFS_VH
`define SDD_DEFS_VH
// Register indices; byte address is four times the index
`define SDD_IDX_MODE_CTRL    4'h0
`define SDD_IDX_THRESHOLD    4'h1
`define SDD_IDX_MARGIN_CTRL  4'h8
`define SDD_IDX_IRQ_CTRL     4'h9
`define SDD_IDX_IRQ_FLAGS    4'ha
`define SDD_IDX_STATUS       4'hb
// Field positions
`define SDD_RATE_BIT         4
`define SDD_AWAKE_HI         3
`define SDD_AWAKE_LO         2
`define SDD_SLEEP_HI         1
`define SDD_SLEEP_LO         0
`define SDD_THR_HI           2
`define SDD_THR_LO           0
`define SDD_MARGIN_HI        1
`define SDD_MARGIN_LO        0
`define SDD_DIR_HI           2
`define SDD_DIR_LO           1
`define SDD_IE_BIT           0
`define SDD_IF_BIT           0
`define SDD_ST_BIT           0
// Detector modes
`define SDD_MODE_OFF         2'h0
`define SDD_MODE_ON          2'h1
`define SDD_MODE_SAMPLED     2'h2
`define SDD_MODE_ON_HOLD     2'h3
// Warning directions
`define SDD_DIR_FALL         2'h0
`define SDD_DIR_RISE         2'h1
`define SDD_DIR_BOTH         2'h2
// Reset values
`define SDD_MARGIN_RST       2'h0
`define SDD_IRQ_CTRL_RST     3'h0
// Unlock key and window (instructions counted as bus writes)
`define SDD_KEY_VALUE        8'hd8
`define SDD_UNLOCK_WINDOW    3'h4
// Sample timing
`define SDD_CLK_HZ           125000000
`define SDD_FAST_HZ          1000
`define SDD_SLOW_HZ          125
`define SDD_FAST_CYCLES      (`SDD_CLK_HZ / `SDD_FAST_HZ)
`define SDD_SLOW_CYCLES      (`SDD_CLK_HZ / `SDD_SLOW_HZ)
`define SDD_WINDOW_CYCLES    17'h00004
`define SDD_CNT_W            20
`endif

// ### src/sdd_sampler.v
// Sample window timer for the sampled detector mode
`timescale 1ns/10ps
`default_nettype none
`include "sdd_defs.vh"
module sdd_sampler #(
  parameter FAST_CYCLES = `SDD_FAST_CYCLES,
  parameter SLOW_CYCLES = `SDD_SLOW_CYCLES
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire       slow,
  output reg        window
);
  reg  [`SDD_CNT_W-1:0] count;
  wire [`SDD_CNT_W-1:0] period;

  assign period = slow ? SLOW_CYCLES[`SDD_CNT_W-1:0]
                       : FAST_CYCLES[`SDD_CNT_W-1:0];

  // Period counter, window open for first cycles of each period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= {`SDD_CNT_W{1'b0}};
      window <= 1'b0;
    end else if (!run) begin
      count  <= {`SDD_CNT_W{1'b0}};
      window <= 1'b0;
    end else begin
      if (count >= period - 1'b1)
        count <= {`SDD_CNT_W{1'b0}};
      else
        count <= count + 1'b1;
      window <= (count < {3'h0, `SDD_WINDOW_CYCLES});
    end
  end
endmodule
`default_nettype wire

// ### tb/sdd_ctrl_properties.sv
// Port checker of the supply drop detector control block
`timescale 1ns/10ps
`default_nettype none
module sdd_ctrl_properties #(
  parameter FAST_CYCLES = 20,
  parameter SLOW_CYCLES = 40
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [5:0] avs_address,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [7:0] detector_fuse_byte,
  input wire logic       deep_sleep,
  input wire logic [1:0] detector_mode,
  input wire logic       detector_enable,
  input wire logic [2:0] threshold_level,
  input wire logic       monitor_enable,
  input wire logic       warning_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Bus answer lasts one cycle and flags unmapped places
  a_answer_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer held longer than one cycle");
  a_unmapped_error: assert property (!avs_waitrequest |-> avs_response ==
    ((avs_address[5:2] inside {4'h0, 4'h1, [4'h8:4'hb]}) ? 2'h0 : 2'h2))
    else $error("bus response code does not match the address");
  // Detector and monitor controls
  a_off_no_compare: assert property (
    detector_mode == 2'h0 && $past(detector_mode) == 2'h0
    |-> !detector_enable && !monitor_enable)
    else $error("comparison active while detector is off");
  a_monitor_follows: assert property (
    monitor_enable |-> detector_enable || $past(detector_enable))
    else $error("warning monitor active without detector");
  a_threshold_fuse: assert property (
    $past(rst_n, 2) |-> threshold_level == detector_fuse_byte[2:0])
    else $error("threshold differs from fuse");
  a_awake_mode_fuse: assert property (
    (!deep_sleep && $past(rst_n, 4))[*5]
    |-> detector_mode == detector_fuse_byte[3:2])
    else $error("awake mode differs from fuse");
  a_irq_request_held: assert property (
    warning_irq && !avs_write && !$past(avs_write) |=> warning_irq)
    else $error("interrupt request dropped without a write");
  a_sample_window: assert property (
    $rose(detector_enable) && detector_mode == 2'h2 |-> detector_enable[*4]
    ##1 (!detector_enable || detector_mode != 2'h2)[*8])
    else $error("sample window length or spacing wrong");

  // Main scenarios reached
  c_window: cover property ($rose(detector_enable) && detector_mode == 2'h2);
  c_irq: cover property ($rose(warning_irq));
  c_error: cover property (!avs_waitrequest && avs_response == 2'h2);
endmodule

bind sdd_ctrl sdd_ctrl_properties #(
  .FAST_CYCLES(FAST_CYCLES),
  .SLOW_CYCLES(SLOW_CYCLES)
) i_sdd_ctrl_properties (
  .clk, .rst_n, .avs_address, .avs_write, .avs_waitrequest,
  .avs_response, .detector_fuse_byte, .deep_sleep, .detector_mode,
  .detector_enable, .threshold_level, .monitor_enable, .warning_irq
);
`default_nettype wire

// ### tb/tb_sdd_ctrl.sv
// Self-checking bench of the supply drop detector control block
`timescale 1ns/10ps
`default_nettype none
`include "sdd_defs.vh"
module tb_sdd_ctrl;
  // Rate 0, awake on, sleep sampled, level 6
  localparam [7:0] FUSE = 8'h06;
  logic        clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [1:0]  avs_response;
  logic        change_protection_write;
  logic [7:0]  change_protection_data;
  logic        deep_sleep;
  logic        below_warning_raw;
  wire  [1:0]  detector_mode;
  wire         detector_enable;
  wire  [2:0]  threshold_level;
  wire  [1:0]  warning_margin;
  wire         monitor_enable;
  wire         warning_irq;
  int          miscompares;
  int          checks;
  logic [7:0]  rd;
  logic [1:0]  rs;
  logic [7:0]  i;
  logic [7:0]  fuse;
  int          n;

  sdd_ctrl #(.FAST_CYCLES(20), .SLOW_CYCLES(40)) i_sdd_ctrl (
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .avs_response,
    .detector_fuse_byte(fuse), .change_protection_write,
    .change_protection_data, .deep_sleep, .below_warning_raw,
    .detector_mode, .detector_enable, .threshold_level, .warning_margin,
    .monitor_enable, .warning_irq
  );

  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= {a, 2'b00};
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // Key write from the protection register
  task automatic key();
    @(posedge clk);
    change_protection_write <= 1'b1;
    change_protection_data  <= `SDD_KEY_VALUE;
    @(posedge clk);
    change_protection_write <= 1'b0;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    fuse = FUSE;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {change_protection_write, change_protection_data} = '0;
    {deep_sleep, below_warning_raw, miscompares, checks} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(`SDD_IDX_MODE_CTRL, FUSE);
    rdc(`SDD_IDX_THRESHOLD, {5'h0, FUSE[2:0]});
    chk({5'h0, threshold_level}, {5'h0, FUSE[2:0]});
    rdc(`SDD_IDX_MARGIN_CTRL, 8'h00);
    rdc(`SDD_IDX_IRQ_CTRL, 8'h00);
    rdc(`SDD_IDX_IRQ_FLAGS, 8'h00);
    rdc(`SDD_IDX_STATUS, 8'h00);
    rdc(4'h2, 8'h00);
    chk({6'h0, rs}, 8'h02);
    $display("test reset values done");
    wr(`SDD_IDX_MODE_CTRL, 8'hfd);
    rdc(`SDD_IDX_MODE_CTRL, 8'h06);
    wr(`SDD_IDX_THRESHOLD, 8'h01);
    rdc(`SDD_IDX_THRESHOLD, 8'h06);
    key();
    wr(`SDD_IDX_MODE_CTRL, 8'hfd);
    rdc(`SDD_IDX_MODE_CTRL, 8'h05);
    key();
    repeat (4) wr(`SDD_IDX_MARGIN_CTRL, 8'h00);
    wr(`SDD_IDX_MODE_CTRL, 8'h02);
    rdc(`SDD_IDX_MODE_CTRL, 8'h05);
    for (i = 8'h00; i < 8'h03; i++) begin
      wr(`SDD_IDX_MARGIN_CTRL, i);
      rdc(`SDD_IDX_MARGIN_CTRL, i);
      chk({6'h0, warning_margin}, i);
    end
    $display("test protection and margin done");
    key();
    wr(`SDD_IDX_MODE_CTRL, 8'h02);
    @(posedge clk) deep_sleep <= 1'b1;
    repeat (6) @(posedge clk);
    chk({6'h0, detector_mode}, 8'h02);
    repeat (60) @(posedge clk);
    deep_sleep <= 1'b0;
    repeat (6) @(posedge clk);
    chk({6'h0, detector_mode}, 8'h01);
    $display("test sleep modes done");
    for (i = 8'h00; i < 8'h03; i++) begin
      wr(`SDD_IDX_IRQ_CTRL, {5'h0, i[1:0], 1'b1});
      wr(`SDD_IDX_IRQ_FLAGS, 8'h01);
      @(posedge clk) below_warning_raw <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(`SDD_IDX_IRQ_FLAGS, {7'h0, i != 8'h01});
      rdc(`SDD_IDX_STATUS, 8'h01);
      wr(`SDD_IDX_IRQ_FLAGS, 8'h01);
      @(posedge clk) below_warning_raw <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(`SDD_IDX_IRQ_FLAGS, {7'h0, i != 8'h00});
      chk({7'h0, warning_irq}, {7'h0, i != 8'h00});
    end
    wr(`SDD_IDX_IRQ_FLAGS, 8'h00);
    rdc(`SDD_IDX_IRQ_FLAGS, 8'h01);
    wr(`SDD_IDX_IRQ_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h00);
    chk({7'h0, monitor_enable}, 8'h00);
    wr(`SDD_IDX_IRQ_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h01);
    chk({7'h0, monitor_enable}, 8'h01);
    wr(`SDD_IDX_IRQ_FLAGS, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h0, warning_irq}, 8'h00);
    $display("test warning flag done");
    key();
    wr(`SDD_IDX_MODE_CTRL, 8'h00);
    @(posedge clk) deep_sleep <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h0, detector_enable}, 8'h00);
    chk({7'h0, monitor_enable}, 8'h00);
    below_warning_raw <= 1'b1;
    repeat (8) @(posedge clk);
    below_warning_raw <= 1'b0;
    repeat (8) @(posedge clk);
    deep_sleep <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(`SDD_IDX_IRQ_FLAGS, 8'h00);
    $display("test disabled detector done");
    // Second reset: slow rate, awake sampled, level 2
    @(posedge clk) rst_n <= 1'b0;
    fuse <= 8'h1a;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(`SDD_IDX_MODE_CTRL, 8'h1a);
    chk({5'h0, threshold_level}, 8'h02);
    chk({6'h0, detector_mode}, 8'h02);
    // Skip a window in progress, then time one full period
    do @(posedge clk); while (detector_enable !== 1'b0);
    do @(posedge clk); while (detector_enable !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (detector_enable !== 1'b0);
    chk(n[7:0], 8'h04);
    do begin
      @(posedge clk);
      n++;
    end while (detector_enable !== 1'b1);
    // Slow period is the instance's 40 cycles
    chk(n[7:0], 8'h28);
    $display("test slow sampled mode done");
    stop_test();
  end

  // Run needs about 450 cycles; cut off far beyond that
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
